/* File: src/can_timing_mask_irq.sv */
module can_timing_mask_irq (
  // clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       clk_en,
  // ahb-lite slave
  input  wire can_tmi_pkg::ahb_req_t      ahb_in,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  // events from the can core
  input  wire logic                       bus_error,
  input  wire logic                       node_state_change,
  input  wire logic                       counter_incremented,
  input  wire logic [14:0]                buffer_done,
  // acceptance filtering request
  input  wire logic                       rx_check,
  input  wire logic                       rx_is_ext,
  input  wire logic                       rx_for_buf14,
  input  wire can_tmi_pkg::can_ident_t    rx_ident,
  input  wire can_tmi_pkg::can_ident_t    buf_ident,
  output logic                            rx_match,
  output can_tmi_pkg::can_ident_t         rx_stored_ident,
  // configuration to the can core
  output can_tmi_pkg::diag_modes_t        diag_modes,
  output logic                            tq_tick,
  output can_tmi_pkg::bit_timing_t        bit_timing,
  // interrupt requests
  output logic                            error_irq,
  output logic [14:0]                     buffer_irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [can_tmi_pkg::cfg_width-1:0] cfg;
    logic [15:0] bit_timing_config;
    logic [15:0] global_accept_mask_base;
    logic [15:0] global_accept_mask_ext;
    logic [15:0] buffer14_accept_mask_base;
    logic [15:0] buffer14_accept_mask_ext;
    logic [15:0] irq_enable;
    logic        error_irq_pending;
    logic [14:0] buffer_irq_pending;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic [7:0]  tq_count;
    logic        tq_tick;
    logic        rx_match;
    can_tmi_pkg::can_ident_t stored;
  } state_t;

  state_t st;
  state_t next_st;

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] mask_word(input logic [15:0] base, input logic [15:0] ext);
    mask_word = {base, ext};
  endfunction

  // 32-bit mask layout: id[28:18] rtr ide id[17:0] ext_remote_mask_bit -> ident layout
  function automatic can_tmi_pkg::can_ident_t mask_to_ident(input logic [31:0] m,
                                                            input logic        is_ext);
    can_tmi_pkg::can_ident_t r;
    r.id         = {m[31:21], m[18:1]};
    r.srr_or_rtr = m[20];
    r.ide        = m[19];
    r.ext_rtr    = m[0];
    if (!is_ext) begin
      r.id[17:0] = '1;
      r.ext_rtr  = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      can_tmi_pkg::addr_cfg:        v = {25'h0, s.cfg};
      can_tmi_pkg::addr_timing:     v = {16'h0, s.bit_timing_config};
      can_tmi_pkg::addr_gmask_base: v = {16'h0, s.global_accept_mask_base};
      can_tmi_pkg::addr_gmask_ext:  v = {16'h0, s.global_accept_mask_ext};
      can_tmi_pkg::addr_bmask_base: v = {16'h0, s.buffer14_accept_mask_base};
      can_tmi_pkg::addr_bmask_ext:  v = {16'h0, s.buffer14_accept_mask_ext};
      can_tmi_pkg::addr_irq_enable: v = {16'h0, s.irq_enable};
      can_tmi_pkg::addr_irq_pend:   v = {16'h0, s.error_irq_pending, s.buffer_irq_pending};
      can_tmi_pkg::addr_bit_time:   v = {7'h00, timing_of(s.bit_timing_config)};
      default:                      v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic can_tmi_pkg::bit_timing_t timing_of(input logic [15:0] t);
    can_tmi_pkg::bit_timing_t b;
    logic [6:0] prescale_code;
    prescale_code = t[can_tmi_pkg::tim_psc_lsb +: 7];
    b.prescaler = (prescale_code == can_tmi_pkg::psc_max_code) ? can_tmi_pkg::psc_cap
                                                     : 8'({1'b0, prescale_code} + 8'h02);
    b.sjw_tq  = 3'({1'b0, t[can_tmi_pkg::tim_sjw_lsb +: 2]} + 3'h1);
    b.seg1_tq = 5'({1'b0, t[can_tmi_pkg::tim_ts1_lsb +: 4]} + 5'h01);
    b.seg2_tq = 4'({1'b0, t[can_tmi_pkg::tim_ts2_lsb +: 3]} + 4'h1);
    b.bit_tq  = 5'(5'h01 + b.seg1_tq + {1'b0, b.seg2_tq});
    return b;
  endfunction

  // ------------------------------------------------------------------
  // acceptance filter
  // ------------------------------------------------------------------
  can_tmi_pkg::can_ident_t mask_sel;
  can_tmi_pkg::can_ident_t care_diff;
  can_tmi_pkg::can_ident_t merged;

  always_comb begin
    mask_sel = mask_to_ident(rx_for_buf14
      ? mask_word(st.buffer14_accept_mask_base, st.buffer14_accept_mask_ext)
      : mask_word(st.global_accept_mask_base, st.global_accept_mask_ext), rx_is_ext);
    care_diff = (rx_ident ^ buf_ident) & ~mask_sel;
    merged    = (rx_ident & mask_sel) | (buf_ident & ~mask_sel);
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic        addr_phase;
  logic        clr_wr;
  logic [15:0] clr_bits;
  logic        err_event;

  always_comb begin
    next_st    = st;
    addr_phase = ahb_in.hsel && ahb_in.hready &&
                 (ahb_in.htrans == can_tmi_pkg::htrans_nonseq ||
                  ahb_in.htrans == can_tmi_pkg::htrans_seq);
    clr_wr     = st.dp_valid && st.dp_write && st.dp_addr == can_tmi_pkg::addr_irq_clear;
    clr_bits   = clr_wr ? ahb_in.hwdata[15:0] : 16'h0000;
    err_event  = st.cfg[can_tmi_pkg::cfg_err_type]
               ? (node_state_change && counter_incremented)
               : bus_error;

    // data phase of a write
    if (st.dp_valid && st.dp_write) begin
      unique case (st.dp_addr)
        can_tmi_pkg::addr_cfg:        next_st.cfg = ahb_in.hwdata[can_tmi_pkg::cfg_width-1:0];
        can_tmi_pkg::addr_timing:     next_st.bit_timing_config = ahb_in.hwdata[15:0];
        can_tmi_pkg::addr_gmask_base: next_st.global_accept_mask_base = ahb_in.hwdata[15:0];
        can_tmi_pkg::addr_gmask_ext:  next_st.global_accept_mask_ext = ahb_in.hwdata[15:0];
        can_tmi_pkg::addr_bmask_base: next_st.buffer14_accept_mask_base = ahb_in.hwdata[15:0];
        can_tmi_pkg::addr_bmask_ext:  next_st.buffer14_accept_mask_ext = ahb_in.hwdata[15:0];
        can_tmi_pkg::addr_irq_enable: next_st.irq_enable = ahb_in.hwdata[15:0];
        default: ;
      endcase
    end

    // pending flags: set wins over a clear in the same cycle
    next_st.error_irq_pending  = (st.error_irq_pending & ~clr_bits[can_tmi_pkg::err_irq_bit])
                               | err_event;
    next_st.buffer_irq_pending = (st.buffer_irq_pending & ~clr_bits[14:0])
                               | buffer_done;

    // address phase capture; read data registered for the data phase
    next_st.dp_valid = addr_phase;
    next_st.dp_write = ahb_in.hwrite;
    next_st.dp_addr  = ahb_in.haddr[7:0];
    next_st.rdata    = (addr_phase && !ahb_in.hwrite) ? read_mux(st, ahb_in.haddr[7:0])
                                                      : 32'h0000_0000;

    // time quantum generator
    next_st.tq_tick = 1'b0;
    if (st.tq_count + 8'h01 >= bit_timing.prescaler) begin
      next_st.tq_count = 8'h00;
      next_st.tq_tick  = 1'b1;
    end else begin
      next_st.tq_count = 8'(st.tq_count + 8'h01);
    end

    // registered filter result
    next_st.rx_match = rx_check && (care_diff == '0);
    if (rx_check && care_diff == '0) begin
      next_st.stored = merged;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  logic diag_on;

  always_comb begin
    diag_on                    = st.cfg[can_tmi_pkg::cfg_diag];
    diag_modes.listen_only     = diag_on & st.cfg[can_tmi_pkg::cfg_listen];
    diag_modes.ack_ignore      = diag_on & st.cfg[can_tmi_pkg::cfg_ack_ignore];
    diag_modes.loopback        = diag_on & st.cfg[can_tmi_pkg::cfg_loopback];
    diag_modes.internal_loop   = diag_on & st.cfg[can_tmi_pkg::cfg_internal];
    diag_modes.hidden_rx_write = diag_on & st.cfg[can_tmi_pkg::cfg_hidden_wr];
    bit_timing      = timing_of(st.bit_timing_config);
    tq_tick         = st.tq_tick;
    hreadyout       = 1'b1;
    hresp           = 1'b0;
    hrdata          = st.rdata;
    rx_match        = st.rx_match;
    rx_stored_ident = st.stored;
    error_irq  = st.error_irq_pending & st.irq_enable[can_tmi_pkg::err_irq_bit];
    buffer_irq = st.buffer_irq_pending & st.irq_enable[14:0];
  end

endmodule // can_timing_mask_irq

/* File: shared/can_tmi_pkg.sv */
package can_tmi_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] addr_cfg        = 8'h00;
  localparam logic [7:0] addr_timing     = 8'h04;
  localparam logic [7:0] addr_gmask_base = 8'h08;
  localparam logic [7:0] addr_gmask_ext  = 8'h0c;
  localparam logic [7:0] addr_bmask_base = 8'h10;
  localparam logic [7:0] addr_bmask_ext  = 8'h14;
  localparam logic [7:0] addr_irq_enable = 8'h18;
  localparam logic [7:0] addr_irq_pend   = 8'h1c;
  localparam logic [7:0] addr_irq_clear  = 8'h20;
  localparam logic [7:0] addr_bit_time   = 8'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int cfg_internal   = 0;
  localparam int cfg_loopback   = 1;
  localparam int cfg_diag       = 2;
  localparam int cfg_err_type   = 3;
  localparam int cfg_listen     = 4;
  localparam int cfg_ack_ignore = 5;
  localparam int cfg_hidden_wr  = 6;
  localparam int cfg_width      = 7;
  localparam int tim_psc_lsb    = 9;
  localparam int tim_sjw_lsb    = 7;
  localparam int tim_ts1_lsb    = 3;
  localparam int tim_ts2_lsb    = 0;
  localparam int err_irq_bit    = 15;
  localparam int num_buffers    = 15;
  localparam logic [15:0] reset_word = 16'h0000;
  localparam logic [6:0]  psc_max_code = 7'h7f;
  localparam logic [7:0]  psc_cap = 8'h80;

  // ----------------------------------------------------------------
  // ahb constants
  // ----------------------------------------------------------------
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq    = 2'h3;
  localparam logic [2:0] hsize_word    = 3'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hwrite;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic [28:0] id;
    logic        srr_or_rtr;
    logic        ide;
    logic        ext_rtr;
  } can_ident_t;

  typedef struct packed {
    logic        listen_only;
    logic        ack_ignore;
    logic        loopback;
    logic        internal_loop;
    logic        hidden_rx_write;
  } diag_modes_t;

  typedef struct packed {
    logic [7:0] prescaler;
    logic [2:0] sjw_tq;
    logic [4:0] seg1_tq;
    logic [3:0] seg2_tq;
    logic [4:0] bit_tq;
  } bit_timing_t;

endpackage

/* File: verif/can_tmi_props.sv */
module can_tmi_props (
  // clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     clk_en,
  // filter requests, filter and timing outputs
  input  wire logic                     rx_check,
  input  wire can_tmi_pkg::can_ident_t  rx_ident,
  input  wire can_tmi_pkg::can_ident_t  buf_ident,
  input  wire logic                     rx_match,
  input  wire can_tmi_pkg::can_ident_t  rx_stored_ident,
  input  wire logic                     tq_tick,
  input  wire can_tmi_pkg::bit_timing_t bit_timing
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_psc_range: assert property (bit_timing.prescaler inside {[8'h02:8'h80]})
    else $error("prescaler out of range");
  chk_jump_range: assert property (bit_timing.sjw_tq inside {[3'h1:3'h4]})
    else $error("jump width out of range");
  chk_seg_one: assert property (bit_timing.seg1_tq inside {[5'h01:5'h10]})
    else $error("segment one out of range");
  chk_seg_two: assert property (bit_timing.seg2_tq inside {[4'h1:4'h8]})
    else $error("segment two out of range");
  chk_bit_sum: assert property (bit_timing.bit_tq ==
    5'h01 + bit_timing.seg1_tq + 5'(bit_timing.seg2_tq)) else $error("bit length wrong");
  chk_tick_gap: assert property ((tq_tick && clk_en) ##1 clk_en |-> !tq_tick)
    else $error("quantum tick too close");
  chk_match_cause: assert property ($rose(rx_match) |-> $past(rx_check))
    else $error("match without request");
  chk_match_equal: assert property ((rx_check && clk_en && rx_ident == buf_ident)
    |=> rx_match) else $error("equal identifiers refused");
  chk_store_hold: assert property ($changed(rx_stored_ident) |-> rx_match)
    else $error("stored identifier moved without match");
  cover property (rx_check ##1 rx_match);
  cover property (rx_check ##1 !rx_match);
  cover property (tq_tick);
endmodule // can_tmi_props

/* File: verif/can_node_model.sv */
module can_node_model (
  // clock
  input  wire logic                    clk,
  // events and filter requests toward the block
  output logic                         bus_error,
  output logic                         node_state_change,
  output logic                         counter_incremented,
  output logic [14:0]                  buffer_done,
  output logic                         rx_check,
  output logic                         rx_is_ext,
  output logic                         rx_for_buf14,
  output can_tmi_pkg::can_ident_t      rx_ident,
  output can_tmi_pkg::can_ident_t      buf_ident
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {bus_error, node_state_change, counter_incremented, buffer_done} = '0;
    {rx_check, rx_is_ext, rx_for_buf14, rx_ident, buf_ident} = '0;
  end

  // one-cycle pulses on bus_error, node_state_change and buffer_done (counter_incremented stays set), then two edges for the pending flags to land
  task automatic fire(input logic be, input logic nsc, input logic ci, input logic [14:0] bd);
    @(posedge clk);
    bus_error <= be;
    node_state_change <= nsc;
    counter_incremented <= ci;
    buffer_done <= bd;
    @(posedge clk);
    bus_error <= 1'b0;
    node_state_change <= 1'b0;
    buffer_done <= '0;
    @(posedge clk);
    #1;
  endtask

  // one filter request; returns while the answer stands
  task automatic filter(input logic ext, input logic b14, input logic [31:0] r,
                        input logic [31:0] b);
    @(posedge clk);
    rx_check <= 1'b1;
    rx_is_ext <= ext;
    rx_for_buf14 <= b14;
    rx_ident <= r;
    buf_ident <= b;
    @(posedge clk);
    rx_check <= 1'b0;
    #1;
  endtask
endmodule // can_node_model

/* File: verif/testbench.sv */
bind can_timing_mask_irq can_tmi_props props_u (.clk(clk), .rstn(rstn), .clk_en(clk_en),
  .rx_check(rx_check), .rx_ident(rx_ident), .buf_ident(buf_ident), .rx_match(rx_match),
  .rx_stored_ident(rx_stored_ident), .tq_tick(tq_tick), .bit_timing(bit_timing));

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic hreadyout, hresp, rx_match, tq_tick, error_irq;
  logic bus_error, node_state_change, counter_incremented, rx_check, rx_is_ext, rx_for_buf14;
  logic [31:0] hrdata, q;
  logic [14:0] buffer_done, buffer_irq;
  can_tmi_pkg::ahb_req_t req = '0, ahb;
  can_tmi_pkg::can_ident_t rx_ident, buf_ident, rx_stored_ident;
  can_tmi_pkg::diag_modes_t diag_modes;
  can_tmi_pkg::bit_timing_t bit_timing;
  int err_count = 0, checks = 0, cyc = 0, n;
  logic [6:0] pc[4] = '{7'h00, 7'h01, 7'h7e, 7'h7f};
  logic [7:0] pe[4] = '{8'h02, 8'h03, 8'h80, 8'h80};
  logic [7:0] ra[7];
  localparam logic [31:0] bid = {29'h1bcdef12, 3'b010};

  always #4 clk = ~clk;
  always_comb begin
    ahb = req;
    ahb.hready = hreadyout;
  end

  can_timing_mask_irq dut_u (.clk(clk), .rstn(rstn), .clk_en(clk_en), .ahb_in(ahb),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_error(bus_error),
    .node_state_change(node_state_change), .counter_incremented(counter_incremented),
    .buffer_done(buffer_done), .rx_check(rx_check), .rx_is_ext(rx_is_ext),
    .rx_for_buf14(rx_for_buf14), .rx_ident(rx_ident), .buf_ident(buf_ident),
    .rx_match(rx_match), .rx_stored_ident(rx_stored_ident), .diag_modes(diag_modes),
    .tq_tick(tq_tick), .bit_timing(bit_timing), .error_irq(error_irq), .buffer_irq(buffer_irq));
  can_node_model nm (.clk(clk), .bus_error(bus_error), .node_state_change(node_state_change),
    .counter_incremented(counter_incremented), .buffer_done(buffer_done), .rx_check(rx_check),
    .rx_is_ext(rx_is_ext), .rx_for_buf14(rx_for_buf14), .rx_ident(rx_ident),
    .buf_ident(buf_ident));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one ahb-lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.hsel <= 1'b1;
    req.haddr <= {24'h000000, a};
    req.htrans <= can_tmi_pkg::htrans_nonseq;
    req.hsize <= can_tmi_pkg::hsize_word;
    req.hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    cmp(q, e);
  endtask

  task automatic flt(input logic ext, input logic b14, input logic [31:0] r, input logic m);
    nm.filter(ext, b14, r, bid);
    cmp(rx_match, m);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    ra = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h3c};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wr(8'h3c, 32'h0000ffff);
    foreach (ra[i]) rd(ra[i], 32'h00000000);
    cmp(bit_timing, {8'h02, 3'h1, 5'h01, 4'h1, 5'h03});
    $display("test reset values done");
    // jump width kept within both segments, segment one code never zero
    for (int i = 0; i < 4; i++) begin
      wr(can_tmi_pkg::addr_timing, {16'h0000, pc[i], 2'(i), 4'(4 * i + 3), 3'(2 * i + 1)});
      cmp(bit_timing, {pe[i], 3'(i + 1), 5'(4 * i + 4), 4'(2 * i + 2), 5'(6 * i + 7)});
    end
    wr(can_tmi_pkg::addr_timing, {16'h0000, 7'h03, 2'h0, 4'h3, 3'h1});
    repeat (2) do @(posedge clk); while (!tq_tick);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!tq_tick && n < 200);
    cmp(n, 5);
    rd(can_tmi_pkg::addr_bit_time, {7'h00, 8'h05, 3'h1, 5'h04, 4'h2, 5'h07});
    $display("test bit timing done");
    wr(can_tmi_pkg::addr_cfg, 32'h0000007b);
    cmp(diag_modes, 5'h00);
    wr(can_tmi_pkg::addr_cfg, 32'h0000007f);
    cmp(diag_modes, 5'h1f);
    wr(can_tmi_pkg::addr_cfg, 32'h00000000);
    $display("test diagnostic gate done");
    wr(can_tmi_pkg::addr_irq_enable, 32'h00008001);
    nm.fire(1'b1, 1'b0, 1'b0, 15'h0000);
    cmp(error_irq, 1'b1);
    wr(can_tmi_pkg::addr_irq_clear, 32'h00000000);
    rd(can_tmi_pkg::addr_irq_pend, 32'h00008000);
    wr(can_tmi_pkg::addr_irq_clear, 32'h00008000);
    cmp(error_irq, 1'b0);
    wr(can_tmi_pkg::addr_cfg, 32'h00000008);
    nm.fire(1'b1, 1'b0, 1'b0, 15'h0000);
    cmp(error_irq, 1'b0);
    nm.fire(1'b0, 1'b1, 1'b0, 15'h0000);
    cmp(error_irq, 1'b0);
    nm.fire(1'b0, 1'b1, 1'b1, 15'h0000);
    cmp(error_irq, 1'b1);
    wr(can_tmi_pkg::addr_irq_clear, 32'h00008000);
    wr(can_tmi_pkg::addr_irq_enable, 32'h00004000);
    nm.fire(1'b0, 1'b1, 1'b1, 15'h4001);
    cmp(error_irq, 1'b0);
    cmp(buffer_irq, 15'h4000);
    rd(can_tmi_pkg::addr_irq_pend, 32'h0000c001);
    $display("test error interrupt done");
    wr(can_tmi_pkg::addr_irq_pend, 32'h00000000);
    wr(can_tmi_pkg::addr_irq_enable, 32'h00007fff);
    cmp(buffer_irq, 15'h4001);
    wr(can_tmi_pkg::addr_irq_clear, 32'h00008001);
    rd(can_tmi_pkg::addr_irq_pend, 32'h00004000);
    wr(can_tmi_pkg::addr_irq_clear, 32'h00004000);
    rd(can_tmi_pkg::addr_irq_pend, 32'h00000000);
    $display("test buffer pending done");
    wr(can_tmi_pkg::addr_gmask_base, 32'h00000000);
    wr(can_tmi_pkg::addr_gmask_ext, 32'h00000000);
    flt(1'b1, 1'b0, bid, 1'b1);
    flt(1'b1, 1'b0, bid ^ 32'h8, 1'b0);
    flt(1'b1, 1'b0, bid ^ 32'h1, 1'b0);
    flt(1'b0, 1'b0, bid ^ 32'h9, 1'b1);
    flt(1'b0, 1'b0, bid ^ 32'h00200000, 1'b0);
    wr(can_tmi_pkg::addr_gmask_ext, 32'h00000002);
    flt(1'b1, 1'b0, bid ^ 32'h8, 1'b1);
    cmp(rx_stored_ident, bid ^ 32'h8);
    wr(can_tmi_pkg::addr_bmask_base, 32'h00008000);
    rd(can_tmi_pkg::addr_bmask_base, 32'h00008000);
    flt(1'b1, 1'b1, bid ^ 32'h80000000, 1'b1);
    flt(1'b1, 1'b0, bid ^ 32'h80000000, 1'b0);
    flt(1'b0, 1'b1, bid ^ 32'h80000009, 1'b1);
    $display("test acceptance masks done");
    give_verdict();
  end
endmodule // testbench
